// ### inc/lpwm_pkg.sv
// package of constants and carrier types for the led pwm grayscale dimming core
package lpwm_pkg;
   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int unsigned NUM_GROUPS    = 3;
   localparam int unsigned CH_PER_GROUP  = 8;
   localparam int unsigned NUM_CH        = 24;
   localparam int unsigned LEVEL_W       = 12;
   localparam int unsigned TRIM_W        = 7;
   localparam int unsigned BRIGHT_W      = 8;
   // ----------------------------------------------------------------
   // group indices and reset values
   // ----------------------------------------------------------------
   localparam int unsigned GRP_RED       = 0;
   localparam int unsigned GRP_GREEN     = 1;
   localparam int unsigned GRP_BLUE      = 2;
   localparam logic [11:0] COUNT_RST     = 12'h000;
   localparam logic [11:0] COUNT_FIRST   = 12'h001;
   localparam logic [11:0] LEVEL_RST     = 12'h000;
   localparam logic [6:0]  TRIM_RST      = 7'h00;
   localparam logic [6:0]  TRIM_MAX      = 7'h7F;
   localparam logic [7:0]  BRIGHT_RST    = 8'h00;
   localparam logic [7:0]  BRIGHT_MAX    = 8'hFF;
   localparam logic        RANGE_HIGH    = 1'b1;
   localparam logic        RANGE_RST     = 1'b1;

   typedef enum logic [1:0] {
      LPWM_ST_BLANK = 2'b00,
      LPWM_ST_RUN   = 2'b01
   } lpwm_state_t;

   // per-channel drive handed to the analog sink
   typedef struct packed {
      logic        on;
      logic [6:0]  trim;
      logic        range_high;
      logic [7:0]  bright;
   } lpwm_sink_t;
endpackage

// ### hdl/lpwm_group.sv
// one colour group: pwm counter and eight channel comparators
`timescale 1ns/10ps
module lpwm_group #(
   parameter int unsigned CH  = 8,
   parameter int unsigned LW  = 12
) (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               blank_n_input,
   input  wire logic               group_pwm_clock,
   input  wire logic [CH*LW-1:0]   pwm_level,
   output logic      [LW-1:0]      count_q,
   output logic      [CH-1:0]      on_q
);
   initial begin
      if (CH < 1 || LW < 2) begin
         $error("lpwm_group: unsupported size");
      end
   end

   logic              clk_prev_q;
   logic              blank_prev_q;
   logic              rise;
   logic [LW-1:0]     count_d;

   // ----------------------------------------------------------------
   // edge detection of the group clock and blank
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_prev_q   <= 1'b0;
         blank_prev_q <= 1'b0;
      end else begin
         clk_prev_q   <= group_pwm_clock;
         blank_prev_q <= blank_n_input;
      end
   end

   assign rise = group_pwm_clock & ~clk_prev_q;

   // ----------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------
   always_comb begin
      count_d = count_q;
      if (!blank_n_input || blank_prev_q && !blank_n_input) begin
         count_d = lpwm_pkg::COUNT_RST[LW-1:0];
      end else if (rise) begin
         count_d = count_q + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_q <= lpwm_pkg::COUNT_RST[LW-1:0];
      end else begin
         count_q <= count_d;
      end
   end

   // ----------------------------------------------------------------
   // comparators: on while 0 < count <= level
   // ----------------------------------------------------------------
   for (genvar c = 0; c < CH; c++) begin : g_ch
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            on_q[c] <= 1'b0;
         end else begin
            on_q[c] <= blank_n_input && (count_d != '0)
                       && (count_d <= pwm_level[c*LW +: LW]);
         end
      end
   end
endmodule

// ### hdl/lpwm_core.sv
// top of the led pwm grayscale dimming core with apb register access
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
// What this block does
// - three 12-bit group counters, one per colour group of eight outputs.
// - each counter steps by one on its own group clock rising edge.
// - blank falling edge clears all three counters to zero together.
// - while blank is low counters stay zero, ignoring group clocks.
// - first group clock edge after blank high gives count one, nonzero outputs on.
// - all outputs off while blank is low, whatever is stored.
// - each channel level is 12 bits, 4096 steps from 0% to 100%.
// - every channel holds its own 7-bit trim code, 128 steps.
// - high range current is one third plus two thirds trim/127, times bright/255.
// - low range current is two thirds trim/127, times bright/255.
// - three range bits in function control pick range per colour group.
// - each group has an 8-bit brightness code, 256 steps, common to its outputs.
// - full current only when on, high range, trim at maximum and brightness at maximum.
// - output on while counter nonzero and not above its level, off once above.
// - level latch strobe updates stored levels at once, even mid-cycle.
module lpwm_core #(
   parameter int unsigned NUM_GROUPS   = 3,
   parameter int unsigned CH_PER_GROUP = 8,
   parameter int unsigned LEVEL_W      = 12,
   parameter int unsigned TRIM_W       = 7,
   parameter int unsigned BRIGHT_W     = 8
) (
   input  wire logic                            pclk,
   input  wire logic                            presetn,
   input  wire logic                            psel,
   input  wire logic                            penable,
   input  wire logic                            pwrite,
   input  wire logic [11:0]                     paddr,
   input  wire logic [31:0]                     pwdata,
   output logic      [31:0]                     prdata,
   output logic                                 pready,
   output logic                                 pslverr,
   input  wire logic                            blank_n_input,
   input  wire logic                            red_group_pwm_clock,
   input  wire logic                            green_group_pwm_clock,
   input  wire logic                            blue_group_pwm_clock,
   input  wire logic                            level_latch_strobe,
   output lpwm_pkg::lpwm_sink_t [23:0]          sink_drive_q
);
   localparam int unsigned NCH = NUM_GROUPS * CH_PER_GROUP;

   // register map: level staging 0x000..0x05C, trim 0x100..0x15C,
   // brightness 0x200..0x208, function control 0x300, counters 0x400..0x408
   localparam logic [11:0] OFS_LEVEL  = 12'h000;
   localparam logic [11:0] OFS_TRIM   = 12'h100;
   localparam logic [11:0] OFS_BRIGHT = 12'h200;
   localparam logic [11:0] OFS_FUNC   = 12'h300;
   localparam logic [11:0] OFS_COUNT  = 12'h400;
   localparam logic [11:0] OFS_STATUS = 12'h500;

   initial begin
      if (NUM_GROUPS != lpwm_pkg::NUM_GROUPS || CH_PER_GROUP != lpwm_pkg::CH_PER_GROUP
          || LEVEL_W != lpwm_pkg::LEVEL_W || TRIM_W != lpwm_pkg::TRIM_W
          || BRIGHT_W != lpwm_pkg::BRIGHT_W) begin
         $error("lpwm_core: sizes must match the sink drive layout");
      end
   end

   logic [LEVEL_W-1:0]          stage_q  [NCH];
   logic [LEVEL_W-1:0]          level_q  [NCH];
   logic [TRIM_W-1:0]           trim_q   [NCH];
   logic [BRIGHT_W-1:0]         bright_q [NUM_GROUPS];
   logic [NUM_GROUPS-1:0]       range_q;
   logic                        strobe_prev_q;
   logic                        strobe_rise;
   logic [NUM_GROUPS*LEVEL_W-1:0]               count_all;
   logic [NUM_GROUPS*CH_PER_GROUP-1:0]          on_all;
   logic [NUM_GROUPS-1:0]                       gclk;
   logic [NCH*LEVEL_W-1:0]                      level_flat;
   logic                        wr_en;
   logic                        rd_en;
   logic [9:0]                  word;
   logic [31:0]                 rdata_d;
   logic                        err_d;

   assign gclk  = {blue_group_pwm_clock, green_group_pwm_clock, red_group_pwm_clock};
   // writes land at the edge where the master samples pready high
   assign wr_en = psel & penable & pwrite & pready;
   assign rd_en = psel & penable & ~pwrite & ~pready;
   assign word  = paddr[11:2];

   // ----------------------------------------------------------------
   // apb handshake: one wait state, answer in the second access cycle
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & err_d;
         prdata  <= rd_en ? rdata_d : 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // read decode and unmapped detection
   // ----------------------------------------------------------------
   always_comb begin
      rdata_d = 32'h0000_0000;
      err_d   = 1'b0;
      if (paddr[1:0] != 2'b00) begin
         err_d = 1'b1;
      end else if (paddr >= OFS_LEVEL && paddr < OFS_LEVEL + 12'(NCH * 4)) begin
         rdata_d = 32'(stage_q[word[4:0]]);
      end else if (paddr >= OFS_TRIM && paddr < OFS_TRIM + 12'(NCH * 4)) begin
         rdata_d = 32'(trim_q[5'(word - OFS_TRIM[11:2])]);
      end else if (paddr >= OFS_BRIGHT && paddr < OFS_BRIGHT + 12'(NUM_GROUPS * 4)) begin
         rdata_d = 32'(bright_q[2'(word - OFS_BRIGHT[11:2])]);
      end else if (paddr == OFS_FUNC) begin
         rdata_d = 32'(range_q);
      end else if (paddr >= OFS_COUNT && paddr < OFS_COUNT + 12'(NUM_GROUPS * 4)) begin
         rdata_d = 32'(count_all[2'(word - OFS_COUNT[11:2]) * LEVEL_W +: LEVEL_W]);
      end else if (paddr == OFS_STATUS) begin
         rdata_d = {7'h00, blank_n_input, on_all};
      end else begin
         err_d = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // staging, trim, brightness and function control writes
   // ----------------------------------------------------------------
   for (genvar i = 0; i < NCH; i++) begin : g_chreg
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            stage_q[i] <= lpwm_pkg::LEVEL_RST;
            trim_q[i]  <= lpwm_pkg::TRIM_RST;
         end else if (wr_en && !err_d) begin
            if (paddr == OFS_LEVEL + 12'(i * 4)) begin
               stage_q[i] <= pwdata[LEVEL_W-1:0];
            end
            if (paddr == OFS_TRIM + 12'(i * 4)) begin
               trim_q[i] <= pwdata[TRIM_W-1:0];
            end
         end
      end
   end

   for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_grpreg
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            bright_q[g] <= lpwm_pkg::BRIGHT_RST;
            range_q[g]  <= lpwm_pkg::RANGE_RST;
         end else if (wr_en && !err_d) begin
            if (paddr == OFS_BRIGHT + 12'(g * 4)) begin
               bright_q[g] <= pwdata[BRIGHT_W-1:0];
            end
            if (paddr == OFS_FUNC) begin
               range_q[g] <= pwdata[g];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // level latch: strobe rising edge copies staging into live levels
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strobe_prev_q <= 1'b0;
      end else begin
         strobe_prev_q <= level_latch_strobe;
      end
   end

   assign strobe_rise = level_latch_strobe & ~strobe_prev_q;

   for (genvar i = 0; i < NCH; i++) begin : g_level
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            level_q[i] <= lpwm_pkg::LEVEL_RST;
         end else if (strobe_rise) begin
            level_q[i] <= stage_q[i];
         end
      end
      assign level_flat[i*LEVEL_W +: LEVEL_W] = level_q[i];
   end

   // ----------------------------------------------------------------
   // three independent group counters
   // ----------------------------------------------------------------
   for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_grp
      lpwm_group #(
         .CH (CH_PER_GROUP),
         .LW (LEVEL_W)
      ) u_group (
         .pclk            (pclk),
         .presetn         (presetn),
         .blank_n_input   (blank_n_input),
         .group_pwm_clock (gclk[g]),
         .pwm_level       (level_flat[g*CH_PER_GROUP*LEVEL_W +: CH_PER_GROUP*LEVEL_W]),
         .count_q         (count_all[g*LEVEL_W +: LEVEL_W]),
         .on_q            (on_all[g*CH_PER_GROUP +: CH_PER_GROUP])
      );
   end

   // ----------------------------------------------------------------
   // sink drive: on gated by blank, trim, range, group brightness
   // ----------------------------------------------------------------
   for (genvar i = 0; i < NCH; i++) begin : g_sink
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            sink_drive_q[i] <= '0;
         end else begin
            sink_drive_q[i].on         <= on_all[i] & blank_n_input;
            sink_drive_q[i].trim       <= trim_q[i];
            sink_drive_q[i].range_high <= range_q[i / CH_PER_GROUP];
            sink_drive_q[i].bright     <= bright_q[i / CH_PER_GROUP];
         end
      end
   end
endmodule

// ### tb/lpwm_host.sv
// host controller model: blank line and three group pwm clocks
`timescale 1ns/10ps
module lpwm_host (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       blank_req,
   input  wire logic [2:0] go,
   input  wire logic [7:0] pulses,
   output logic            blank_n_input,
   output logic [2:0]      gclk,
   output logic            busy
);
   logic [2:0] busy_v;
   assign busy = |busy_v;
   // blank stays low from reset until the bench has loaded levels
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blank_n_input <= 1'b0;
      end else begin
         blank_n_input <= blank_req;
      end
   end
   // a pulse is one pclk high then one low; the clock stands low between bursts
   for (genvar g = 0; g < 3; g++) begin : gen_clk
      logic [8:0] left_q;
      logic       clk_q;
      assign gclk[g] = clk_q;
      assign busy_v[g] = |left_q;
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            left_q <= 9'h000;
            clk_q <= 1'b0;
         end else if (go[g]) begin
            left_q <= {pulses, 1'b0};
         end else if (left_q != 9'h000) begin
            left_q <= left_q - 9'h001;
            clk_q <= ~clk_q;
         end
      end
   end
endmodule

// ### tb/lpwm_core_properties.sv
// concurrent checks on the ports of the pwm core
`timescale 1ns/10ps
module lpwm_core_chk (
   input wire logic                   pclk,
   input wire logic                   presetn,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [11:0]            paddr,
   input wire logic [31:0]            pwdata,
   input wire logic [31:0]            prdata,
   input wire logic                   pready,
   input wire logic                   pslverr,
   input wire logic                   blank_n_input,
   input wire logic                   red_group_pwm_clock,
   input wire logic                   green_group_pwm_clock,
   input wire logic                   blue_group_pwm_clock,
   input wire logic                   level_latch_strobe,
   input lpwm_pkg::lpwm_sink_t [23:0] sink_drive_q
);
   logic [23:0] on_v;
   logic        bright_ok;
   logic        range_ok;
   // group-wide fields must agree across the eight channels of a group
   always_comb begin
      bright_ok = 1'b1;
      range_ok = 1'b1;
      for (int i = 0; i < 24; i++) begin
         on_v[i] = sink_drive_q[i].on;
         bright_ok &= sink_drive_q[i].bright == sink_drive_q[(i / 8) * 8].bright;
         range_ok &= sink_drive_q[i].range_high == sink_drive_q[(i / 8) * 8].range_high;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable ##1 psel && penable;
   endsequence
   sequence s_blanked;
      !blank_n_input [*3];
   endsequence
   AST_READY_AFTER_ACCESS: assert property (s_setup |=> pready)
      else $error("pready missing after access");
   AST_READY_ONE: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   AST_READY_CAUSE: assert property (pready |-> $past(psel && penable))
      else $error("pready without access");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("prdata not zero outside answer");
   AST_BLANK_OFF: assert property (s_blanked |-> on_v == 24'h00_0000)
      else $error("output on while blanked");
   AST_BRIGHT_COMMON: assert property (blank_n_input |-> bright_ok)
      else $error("brightness differs in group");
   AST_RANGE_COMMON: assert property ($rose(blank_n_input) |-> ##2 range_ok)
      else $error("range differs in group");
endmodule
bind lpwm_core lpwm_core_chk lpwm_core_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .blank_n_input(blank_n_input), .red_group_pwm_clock(red_group_pwm_clock),
   .green_group_pwm_clock(green_group_pwm_clock), .blue_group_pwm_clock(blue_group_pwm_clock),
   .level_latch_strobe(level_latch_strobe), .sink_drive_q(sink_drive_q));

// ### tb/lpwm_core_test.sv
// self-checking bench for the pwm core
`timescale 1ns/10ps
module lpwm_core_test;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, strobe = 0, blank_req = 0, busy, blank_n;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic pready, pslverr, er;
   logic [2:0] go = 3'b000, gclk;
   logic [7:0] pulses = 8'h00;
   lpwm_pkg::lpwm_sink_t [23:0] sink;
   int fail_count = 0, checks_done = 0;
   always #12.5 pclk = ~pclk;
   lpwm_core lpwm_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .blank_n_input(blank_n), .red_group_pwm_clock(gclk[0]), .green_group_pwm_clock(gclk[1]),
      .blue_group_pwm_clock(gclk[2]), .level_latch_strobe(strobe), .sink_drive_q(sink));
   lpwm_host lpwm_host_i (.pclk(pclk), .presetn(presetn), .blank_req(blank_req), .go(go), .pulses(pulses),
      .blank_n_input(blank_n), .gclk(gclk), .busy(busy));
   task automatic wrap_up();
      if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      checks_done++;
      if (s !== x) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, x, s);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         fail_count++;
         wrap_up();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, rd, x);
   endtask
   task automatic pulse(input logic [2:0] m, input logic [7:0] n);
      int k;
      go <= m;
      pulses <= n;
      @(posedge pclk);
      go <= 3'b000;
      repeat (2) @(posedge pclk);
      for (k = 0; busy !== 1'b0 && k < 600; k++) @(posedge pclk);
      if (k >= 600) begin
         fail_count++;
         wrap_up();
      end
      repeat (2) @(posedge pclk);
   endtask
   task automatic latch();
      strobe <= 1'b1;
      @(posedge pclk);
      strobe <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rchk("level0", 12'h000, 32'h0000_0000);
      rchk("trim5", 12'h114, 32'h0000_0000);
      rchk("bright", 12'h200, 32'h0000_0000);
      rchk("range", 12'h300, 32'h0000_0007);
      rchk("unmapped", 12'hFFC, 32'h0000_0000);
      chk("slverr", {31'b0, er}, 32'h0000_0001);
      // trim and brightness loaded while still blanked
      for (int i = 0; i < 24; i++) apb(1'b1, 12'h100 + 12'(4 * i), 32'h0000_00FF);
      for (int g = 0; g < 3; g++) apb(1'b1, 12'h200 + 12'(4 * g), 32'h0000_00FF);
      apb(1'b1, 12'h300, 32'h0000_0005);
      apb(1'b1, 12'h000, 32'h0000_0003);
      apb(1'b1, 12'h040, 32'hFFFF_FFFF);
      rchk("level16", 12'h040, 32'h0000_0FFF);
      rchk("trim5", 12'h114, 32'h0000_007F);
      latch();
      pulse(3'b001, 8'd5);
      rchk("red_blank", 12'h400, 32'h0000_0000);
      rchk("status_blank", 12'h500, 32'h0000_0000);
      blank_req <= 1'b1;
      repeat (2) @(posedge pclk);
      pulse(3'b001, 8'd1);
      rchk("red_first", 12'h400, 32'h0000_0001);
      rchk("status_first", 12'h500, 32'h0100_0001);
      chk("sink0", {15'h0000, sink[0]}, 32'h0001_FFFF);
      chk("green_range", {31'b0, sink[8].range_high}, 32'h0000_0000);
      chk("blue_range", {31'b0, sink[16].range_high}, 32'h0000_0001);
      chk("bright7", {24'h00_0000, sink[7].bright}, 32'h0000_00FF);
      pulse(3'b101, 8'd2);
      rchk("red_count", 12'h400, 32'h0000_0003);
      rchk("green_count", 12'h404, 32'h0000_0000);
      rchk("status_eq", 12'h500, 32'h0101_0001);
      pulse(3'b001, 8'd1);
      rchk("status_past", 12'h500, 32'h0101_0000);
      apb(1'b1, 12'h000, 32'h0000_000A);
      latch();
      rchk("status_latch", 12'h500, 32'h0101_0001);
      blank_req <= 1'b0;
      repeat (3) @(posedge pclk);
      rchk("red_clear", 12'h400, 32'h0000_0000);
      rchk("blue_clear", 12'h408, 32'h0000_0000);
      rchk("status_off", 12'h500, 32'h0000_0000);
      wrap_up();
   end
endmodule
